// File: core/p9gp_pkg.sv
/*
  Package for the eight-bit general-purpose port block: register map, reset values, field positions,
  pin-function constants and the packed structs for pin signals, control signals and register state.
  Assumes APB with 32-bit data; each register sits at four times its index as a byte address.
*/
package p9gp_pkg;
  localparam int P9GP_WIDTH = 8;
  // Register indices; byte address is four times the index
  localparam logic [15:0] P9GP_IDX_DIR = 16'hffc0;
  localparam logic [15:0] P9GP_IDX_OUT = 16'hffc1;
  localparam logic [17:0] P9GP_ADDR_DIR = {P9GP_IDX_DIR, 2'b00};
  localparam logic [17:0] P9GP_ADDR_OUT = {P9GP_IDX_OUT, 2'b00};
  localparam int P9GP_ADDR_W = 18;
  // Own control register: mode, slave select, software standby control
  localparam logic [17:0] P9GP_ADDR_CTRL = 18'h3ff08;
  localparam int P9GP_CTRL_MODE3 = 0;
  localparam int P9GP_CTRL_SLAVE = 1;
  localparam int P9GP_CTRL_SWSTBY = 2;
  // Reset values of the direction register per mode group
  localparam logic [7:0] P9GP_DIR_RST_M12 = 8'h40;
  localparam logic [7:0] P9GP_DIR_RST_M3 = 8'h00;
  localparam logic [7:0] P9GP_OUT_RST = 8'h00;
  localparam logic [7:0] P9GP_DIR_READ = 8'hff;
  // Bit that carries the system clock output
  localparam int P9GP_CLK_BIT = 6;
  localparam logic [31:0] P9GP_RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
  } p9gp_pins_t;

  typedef struct packed {
    logic mode3;
    logic hw_standby;
    logic sw_standby;
    logic slave_cfg_sel;
  } p9gp_ctrl_t;

  typedef struct packed {
    logic [7:0] port_dir_reg;
    logic [7:0] port_out_reg;
    logic mode3_reg;
    logic slave_cfg_reg;
    logic sw_standby_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] pin_out_reg;
    logic [7:0] pin_oe_n_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [1:0] pin_sel_lo_reg;
    logic first_reg;
  } p9gp_state_t;
endpackage

// File: core/p9gp_port.sv
/*
  Eight-bit general-purpose port: write-only direction register, data register with a pin-level bit,
  mode-dependent reset values, standby retention, and an APB slave for register access.
  Assumes mode and hardware standby come from chip control as synchronous levels; pins pass a
  two-flop synchroniser before they are read.
*/
// Our own choice: the APB interface to the registers.
//
// Contract
// (RULE1) Eight pins, each independently input or output, shared with other functions.
// (RULE2) Lowest two pins follow slave-configuration select; upper six ignore it.
// (RULE3) Direction bit 1 drives pin as output; 0 leaves it input.
// (RULE4) In modes 1 and 2 direction bit 6 stays 1; writes ignored.
// (RULE5) Direction register is write-only; reads return all ones.
// (RULE6) Reset or hardware standby loads direction 0x40 in modes 1-2, 0x00 in mode 3; reset here loads 0x40, mode 3 gets 0x00 on the first enabled edge.
// (RULE7) Software standby keeps direction contents; output pins stay driven.
// (RULE8) Direction register decoded at index 0xffc0 as eight-bit location.
// (RULE9) Data register at 0xffc1; bit 6 read-only pin level; others reset 0.
// (RULE10) Read returns data where direction 1, pin level where 0; bit 6 always pin.
// (RULE11) Data register keeps values in software standby; reset and hardware standby clear it.
// (RULE12) Register writes update value and pin drive on the completing clock edge.
`timescale 1ns/1ps
`default_nettype none
module p9gp_port
  import p9gp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Chip control
  input wire logic mode3,
  input wire logic hw_standby,
  input wire logic sys_clk_out,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [p9gp_pkg::P9GP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  // Synchronised levels of the low two pins for slave-side functions; all ones when not selected
  output logic [1:0] pin_sel_lo
);
  import p9gp_pkg::*;

  p9gp_state_t s_reg;
  p9gp_state_t s_next;

  logic setup;
  logic wr;
  logic [7:0] dir_rst;
  logic [7:0] wdir;
  logic [7:0] read_val;

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pwrite && s_reg.pready_reg;
    dir_rst = mode3 ? P9GP_DIR_RST_M3 : P9GP_DIR_RST_M12;
    wdir = pwdata[7:0];
    // Pin 6 direction forced in modes 1 and 2
    if (!mode3) begin
      wdir[P9GP_CLK_BIT] = 1'b1; // [RULE4]
    end
    // Direction 1 reads latch, 0 reads pin; bit 6 always reads pin
    read_val = (s_reg.port_dir_reg & s_reg.port_out_reg) | (~s_reg.port_dir_reg & s_reg.sync2_reg); // [RULE10]
    read_val[P9GP_CLK_BIT] = s_reg.sync2_reg[P9GP_CLK_BIT]; // [RULE9] [RULE10]

    s_next = s_reg;
    s_next.sync1_reg = pin_in;
    s_next.sync2_reg = s_reg.sync1_reg;
    s_next.mode3_reg = mode3;
    s_next.first_reg = 1'b0;
    // One wait state: pready is high in the second access cycle
    s_next.pready_reg = psel && penable && !s_reg.pready_reg;
    s_next.pslverr_reg = 1'b0;

    if (setup) begin
      s_next.prdata_reg = P9GP_RD_ZERO;
      s_next.pslverr_reg = 1'b0;
      case (paddr)
        P9GP_ADDR_DIR: s_next.prdata_reg = {24'h000000, P9GP_DIR_READ}; // [RULE5] [RULE8]
        P9GP_ADDR_OUT: s_next.prdata_reg = {24'h000000, read_val}; // [RULE9]
        P9GP_ADDR_CTRL: s_next.prdata_reg = {29'h0, s_reg.sw_standby_reg, s_reg.slave_cfg_reg, s_reg.mode3_reg};
        default: s_next.prdata_reg = P9GP_RD_ZERO;
      endcase
    end
    if (psel && penable && !s_reg.pready_reg) begin
      case (paddr)
        P9GP_ADDR_DIR, P9GP_ADDR_OUT, P9GP_ADDR_CTRL: s_next.pslverr_reg = 1'b0;
        default: s_next.pslverr_reg = 1'b1;
      endcase
    end

    // Writes land on the completing edge; standby does not block software writes here
    if (wr) begin
      case (paddr)
        P9GP_ADDR_DIR: s_next.port_dir_reg = wdir; // [RULE3] [RULE8] [RULE12]
        P9GP_ADDR_OUT: begin
          s_next.port_out_reg = pwdata[7:0]; // [RULE12]
          s_next.port_out_reg[P9GP_CLK_BIT] = 1'b0; // [RULE9]
        end
        P9GP_ADDR_CTRL: begin
          s_next.slave_cfg_reg = pwdata[P9GP_CTRL_SLAVE];
          s_next.sw_standby_reg = pwdata[P9GP_CTRL_SWSTBY];
        end
        default: s_next.slave_cfg_reg = s_reg.slave_cfg_reg;
      endcase
    end

    // Mode change re-forces the fixed direction bit at once
    if (!mode3) begin
      s_next.port_dir_reg[P9GP_CLK_BIT] = 1'b1; // [RULE4]
    end

    // Hardware standby acts like reset; so does the first enabled edge after reset, which
    // picks the mode 3 direction value that the constant-only reset branch cannot know
    if (hw_standby || s_reg.first_reg) begin
      s_next.port_dir_reg = dir_rst; // [RULE6]
      s_next.port_out_reg = P9GP_OUT_RST; // [RULE11]
      s_next.sw_standby_reg = 1'b0;
    end
    // Retention in software standby is simply the absence of any clear [RULE7] [RULE11]

    // Pin drive from next register values so a write shows on the same edge
    for (int i = 0; i < P9GP_WIDTH; i++) begin
      s_next.pin_oe_n_reg[i] = ~s_next.port_dir_reg[i]; // [RULE1] [RULE3] [RULE7]
      s_next.pin_out_reg[i] = s_next.port_out_reg[i];
    end
    // Pin 6 as output carries the system clock level
    s_next.pin_out_reg[P9GP_CLK_BIT] = sys_clk_out;
    // Low two pins go to slave-side functions only when selected; upper six ignore the select
    s_next.pin_sel_lo_reg = s_reg.slave_cfg_reg ? s_reg.sync2_reg[1:0] : 2'b11; // [RULE2]
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.port_dir_reg <= P9GP_DIR_RST_M12; // [RULE6]
      s_reg.pin_oe_n_reg <= ~P9GP_DIR_RST_M12;
      s_reg.port_out_reg <= P9GP_OUT_RST;
      s_reg.pin_sel_lo_reg <= 2'b11;
      // Limitation: in mode 3 pin 6 drives until the first enabled edge after release
      s_reg.first_reg <= 1'b1; // [RULE6]
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata_reg;
  assign pready = s_reg.pready_reg;
  assign pslverr = s_reg.pslverr_reg;
  assign pin_out = s_reg.pin_out_reg;
  assign pin_oe_n = s_reg.pin_oe_n_reg;
  assign pin_sel_lo = s_reg.pin_sel_lo_reg;
endmodule
`default_nettype wire

// File: tb/p9gp_pin_model.sv
/* Pin model: the level seen on each port pin.
   Assumes pin_oe_n low means the port drives that pin. */
`timescale 1ns/1ps
`default_nettype none
module p9gp_pin_model (
  // Port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // Outside level on undriven pins
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  always_comb pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule
`default_nettype wire

// File: tb/p9gp_port_tb_top.sv
/* Bench for the eight-bit port: APB task, pin model, directed tests.
   Assumes one wait state per transfer and a fixed outside pin pattern. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module p9gp_port_tb_top;
  import p9gp_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, mode3 = 1'b0, hw_standby = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic clk_en = 1'b1, sys_clk_out = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [7:0] pin_in, pin_out, pin_oe_n, ext_val = 8'h3c;
  logic [1:0] pin_sel_lo;
  int miscompares = 0, comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  p9gp_port dut (.clk_sys, .reset_n, .clk_en, .mode3, .hw_standby, .sys_clk_out, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_sel_lo);
  p9gp_pin_model pins (.pin_out, .pin_oe_n, .ext_val, .pin_in);
  task automatic xfer(input logic [17:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic hw_pulse(input logic m);
    mode3 <= m;
    hw_standby <= 1'b1;
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    `CHK(pin_oe_n, 8'hbf)
    xfer(P9GP_ADDR_DIR, 1'b0, 32'h0);
    `CHK(q, 32'h0000_00ff)
    $display("reset test done");
    xfer(P9GP_ADDR_OUT, 1'b1, 32'h0000_00a5);
    xfer(P9GP_ADDR_DIR, 1'b1, 32'h0000_000f);
    `CHK(pin_oe_n, 8'hb0)
    `CHK(pin_out[5:0], 6'h25)
    repeat (3) @(posedge clk_sys);
    xfer(P9GP_ADDR_OUT, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0035)
    xfer(P9GP_ADDR_CTRL, 1'b1, 32'h0000_0004);
    xfer(P9GP_ADDR_OUT, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0035)
    `CHK(pin_oe_n, 8'hb0)
    xfer(18'h3ff0c, 1'b0, 32'h0);
    `CHK(err, 1'b1)
    $display("data and standby test done");
    xfer(P9GP_ADDR_CTRL, 1'b1, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    `CHK(pin_sel_lo, 2'b01)
    xfer(P9GP_ADDR_CTRL, 1'b1, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(pin_sel_lo, 2'b11)
    hw_pulse(1'b0);
    `CHK(pin_oe_n, 8'hbf)
    `CHK(pin_out[5:0], 6'h00)
    hw_pulse(1'b1);
    `CHK(pin_oe_n, 8'hff)
    xfer(P9GP_ADDR_DIR, 1'b1, 32'h0000_0040);
    `CHK(pin_oe_n, 8'hbf)
    $display("select and mode test done");
    // Mid-run reset in mode 3: the first enabled edge must load the mode 3 direction value
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(pin_oe_n, 8'hff)
    `CHK(pin_out[5:0], 6'h00)
    xfer(P9GP_ADDR_DIR, 1'b1, 32'h0000_0040);
    sys_clk_out <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(pin_out[6], 1'b1)
    clk_en <= 1'b0;
    sys_clk_out <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(pin_out[6], 1'b1)
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(pin_out[6], 1'b0)
    $display("reset and enable test done");
    wrap_up();
  end
  // Tests need about 82 cycles
  initial begin
    #50000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire

// File: tb/p9gp_properties.sv
/* Checker for the eight-bit port, bound to its top module.
   Assumes no register write within two cycles of a standby pulse. */
`timescale 1ns/1ps
`default_nettype none
module p9gp_props
  import p9gp_pkg::*;
(
  // Clock, reset, control
  input wire logic clk_sys, reset_n, mode3, hw_standby,
  // APB
  input wire logic psel, penable, pwrite, pready, pslverr,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins
  input wire logic [7:0] pin_out, pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire wr_done = psel && penable && pready && pwrite;
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_LATENCY: assert property (psel && !penable |-> ##2 pready)
    else $error("answer late");
  AST_DIR_READ: assert property (pready && !pwrite && paddr == P9GP_ADDR_DIR |-> prdata == 32'h0000_00ff)
    else $error("direction read not all ones");
  AST_WR_DIR: assert property (wr_done && paddr == P9GP_ADDR_DIR |=> ~pin_oe_n[5:0] == $past(pwdata[5:0]))
    else $error("direction write not on pins");
  AST_WR_OUT: assert property (wr_done && paddr == P9GP_ADDR_OUT |=> pin_out[5:0] == $past(pwdata[5:0]))
    else $error("data write not on pins");
  AST_M12_CLK_PIN: assert property (!mode3 |=> !pin_oe_n[6])
    else $error("pin 6 not output in modes 1 and 2");
  AST_HW_STBY: assert property (hw_standby |-> ##2 pin_oe_n == ~(mode3 ? P9GP_DIR_RST_M3 : P9GP_DIR_RST_M12))
    else $error("standby direction value wrong");
  AST_UNMAPPED: assert property (pslverr |-> pready && paddr != P9GP_ADDR_DIR && paddr != P9GP_ADDR_OUT)
    else $error("error on mapped address");
endmodule
bind p9gp_port p9gp_props u_props (.*);
`default_nettype wire
